// >>> verilog/acps_defs.svh
// Register offset, field positions, reset values and map constants of the aux control block.
`ifndef ACPS_DEFS_SVH
`define ACPS_DEFS_SVH
`define ACPS_AUX_CONTROL_ADDR 8'hA2
`define ACPS_POINTER_SELECT_BIT 0
`define ACPS_ZERO_BIT 2
`define ACPS_USER_FLAG_BIT 3
`define ACPS_BOOT_SPACE_BIT 5
`define ACPS_WRITABLE_MASK 8'h29
`define ACPS_BOOT_BASE 16'hF800
`define ACPS_BOOT_TOP 16'hFFFF
`define ACPS_POINTER_RESET 16'h0000
`endif

// >>> verilog/acps_pkg.sv
// Types shared by the aux control block.
package acps_pkg;
  typedef enum logic [1:0] {
    ACPS_PTR_HOLD,
    ACPS_PTR_LOAD,
    ACPS_PTR_INC
  } acps_ptr_op_t;
endpackage : acps_pkg

// >>> verilog/acps_boot_map.sv
// Decoder that tells whether a code address falls in the mapped boot flash window.
`timescale 1ns/1ps
`include "acps_defs.svh"
module acps_boot_map (
  input wire logic boot_space_enable_i,
  input wire logic [15:0] code_addr_i,
  output logic boot_hit_o
);
  always_comb begin
    boot_hit_o = boot_space_enable_i && (code_addr_i >= `ACPS_BOOT_BASE) &&
                 (code_addr_i <= `ACPS_BOOT_TOP); // see [RULE1]
  end
endmodule : acps_boot_map

// >>> verilog/acps_aux_control.sv
// Aux control register with dual data pointer storage and boot flash mapping.
// Summary of operation
// [RULE1] Boot space bit maps boot flash at top.
// [RULE2] User flag is plain storage, no effect.
// [RULE3] Bit two always reads zero, ignores writes.
// [RULE4] Pointer select chooses active data pointer.
// [RULE5] Software never sets reserved bits 7,6,4,1.
// [RULE6] Reset clears select, boot bit from fuse.
// [RULE7] Increment toggles select, keeps user flag.
// [RULE8] Two independent 16-bit data pointers.
// [RULE9] Writes update bits 5,3,0 only, next cycle.
`timescale 1ns/1ps
`include "acps_defs.svh"
module acps_aux_control (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic boot_jump_fuse_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  output logic sfr_hit_o,
  input wire acps_pkg::acps_ptr_op_t ptr_op_i,
  input wire logic [15:0] ptr_wdata_i,
  output logic [15:0] active_pointer_o,
  output logic pointer_select_o,
  output logic user_flag_o,
  output logic boot_space_enable_o,
  input wire logic [15:0] code_addr_i,
  output logic boot_hit_o
);
  typedef struct packed {
    logic reset_seen;
    logic pointer_select;
    logic user_flag;
    logic boot_space_enable;
    logic [15:0] data_pointer_zero;
    logic [15:0] data_pointer_one;
  } acps_state_t;

  acps_state_t state_q;
  acps_state_t state_d;
  logic sel_wr;

  function automatic logic [15:0] acps_ptr_next(input acps_pkg::acps_ptr_op_t op,
                                                input logic [15:0] cur,
                                                input logic [15:0] wdata);
    logic [15:0] res;
    res = cur;
    unique case (op)
      acps_pkg::ACPS_PTR_HOLD: res = cur;
      acps_pkg::ACPS_PTR_LOAD: res = wdata;
      acps_pkg::ACPS_PTR_INC: res = cur + 16'h0001;
      default: res = cur;
    endcase
    return res;
  endfunction : acps_ptr_next

  // The address decode feeds both the write strobe and the hit flag, so it lives in one place.
  function automatic logic acps_addr_hit(input logic [7:0] addr);
    return addr == `ACPS_AUX_CONTROL_ADDR;
  endfunction : acps_addr_hit

  assign sel_wr = sfr_wr_i && acps_addr_hit(sfr_addr_i);
  assign sfr_hit_o = acps_addr_hit(sfr_addr_i);

  always_comb begin
    state_d = state_q;
    state_d.reset_seen = rst_i;
    if (rst_i) begin
      state_d.pointer_select = 1'b0; // see [RULE6]
      state_d.user_flag = 1'b0;
      // The fuse is a static level while reset is held, so it is taken without a synchroniser.
      state_d.boot_space_enable = boot_jump_fuse_i; // see [RULE6]
      state_d.data_pointer_zero = `ACPS_POINTER_RESET;
      state_d.data_pointer_one = `ACPS_POINTER_RESET;
    end else begin
      if (state_q.pointer_select) begin
        state_d.data_pointer_one = acps_ptr_next(ptr_op_i, state_q.data_pointer_one,
                                                 ptr_wdata_i); // see [RULE8]
      end else begin
        state_d.data_pointer_zero = acps_ptr_next(ptr_op_i, state_q.data_pointer_zero,
                                                  ptr_wdata_i); // see [RULE8]
      end
      // Only bits 5, 3 and 0 have storage; bit 1 reads zero, so an increment's carry dies there.
      if (sel_wr) begin
        state_d.pointer_select = sfr_wdata_i[`ACPS_POINTER_SELECT_BIT]; // see [RULE9]
        state_d.user_flag = sfr_wdata_i[`ACPS_USER_FLAG_BIT]; // see [RULE2]
        state_d.boot_space_enable = sfr_wdata_i[`ACPS_BOOT_SPACE_BIT]; // see [RULE9]
      end
    end
  end

  // Reset is folded into the next-state logic so that one register process holds all state.
  always_ff @(posedge clk_i) begin
    state_q <= state_d;
  end

  always_comb begin
    // Reserved bits read as zero; software must treat them as undefined anyway.
    sfr_rdata_o = 8'h00; // see [RULE5]
    sfr_rdata_o[`ACPS_POINTER_SELECT_BIT] = state_q.pointer_select;
    sfr_rdata_o[`ACPS_USER_FLAG_BIT] = state_q.user_flag;
    sfr_rdata_o[`ACPS_BOOT_SPACE_BIT] = state_q.boot_space_enable;
    sfr_rdata_o[`ACPS_ZERO_BIT] = 1'b0; // see [RULE3]
  end

  assign active_pointer_o = state_q.pointer_select ? state_q.data_pointer_one
                                                   : state_q.data_pointer_zero; // see [RULE4]
  assign pointer_select_o = state_q.pointer_select;
  assign user_flag_o = state_q.user_flag;
  assign boot_space_enable_o = state_q.boot_space_enable;

  acps_boot_map u_boot_map (
    .boot_space_enable_i(state_q.boot_space_enable),
    .code_addr_i(code_addr_i),
    .boot_hit_o(boot_hit_o)
  );

  property p_zero_bit;
    @(posedge clk_i) disable iff (rst_i) sfr_rdata_o[`ACPS_ZERO_BIT] == 1'b0;
  endproperty
  a_zero_bit: assert property (p_zero_bit) // see [RULE3]
    else $error("bit two read nonzero");

  property p_write_select;
    @(posedge clk_i) disable iff (rst_i)
      sel_wr |=> pointer_select_o == $past(sfr_wdata_i[`ACPS_POINTER_SELECT_BIT]);
  endproperty
  a_write_select: assert property (p_write_select) // see [RULE9]
    else $error("select not written");

  property p_write_flag;
    @(posedge clk_i) disable iff (rst_i)
      sel_wr |=> user_flag_o == $past(sfr_wdata_i[`ACPS_USER_FLAG_BIT]) &&
                 boot_space_enable_o == $past(sfr_wdata_i[`ACPS_BOOT_SPACE_BIT]);
  endproperty
  a_write_flag: assert property (p_write_flag) // see [RULE2]
    else $error("flag bits not written");

  property p_hold;
    @(posedge clk_i) disable iff (rst_i)
      !sel_wr |=> $stable(pointer_select_o) && $stable(user_flag_o) &&
                  $stable(boot_space_enable_o);
  endproperty
  a_hold: assert property (p_hold) // see [RULE9]
    else $error("register changed without write");

  // The core's increment may carry into reserved bit 1, so only the stored bits are compared.
  sequence s_inc_write;
    sel_wr && ((sfr_wdata_i & `ACPS_WRITABLE_MASK) ==
               ((sfr_rdata_o + 8'h01) & `ACPS_WRITABLE_MASK));
  endsequence
  sequence s_select_toggled;
    pointer_select_o != $past(pointer_select_o) && user_flag_o == $past(user_flag_o);
  endsequence
  property p_increment;
    @(posedge clk_i) disable iff (rst_i) s_inc_write |=> s_select_toggled;
  endproperty
  a_increment: assert property (p_increment) // see [RULE7]
    else $error("increment misbehaved");

  // A select flip with no pointer operation must bring the other stored pointer out.
  property p_select_mux;
    @(posedge clk_i) disable iff (rst_i)
      sel_wr && ptr_op_i == acps_pkg::ACPS_PTR_HOLD &&
      sfr_wdata_i[`ACPS_POINTER_SELECT_BIT] != pointer_select_o |=>
        active_pointer_o == (pointer_select_o ? $past(state_q.data_pointer_one)
                                              : $past(state_q.data_pointer_zero));
  endproperty
  a_select_mux: assert property (p_select_mux) // see [RULE4]
    else $error("wrong pointer active");

  property p_other_pointer;
    @(posedge clk_i) disable iff (rst_i)
      !pointer_select_o |=> state_q.data_pointer_one == $past(state_q.data_pointer_one);
  endproperty
  a_other_pointer: assert property (p_other_pointer) // see [RULE8]
    else $error("idle pointer moved");

  property p_other_pointer_zero;
    @(posedge clk_i) disable iff (rst_i)
      pointer_select_o |=> state_q.data_pointer_zero == $past(state_q.data_pointer_zero);
  endproperty
  a_other_pointer_zero: assert property (p_other_pointer_zero) // see [RULE8]
    else $error("idle pointer zero moved");

  property p_load;
    @(posedge clk_i) disable iff (rst_i)
      ptr_op_i == acps_pkg::ACPS_PTR_LOAD && !sel_wr |=> active_pointer_o == $past(ptr_wdata_i);
  endproperty
  a_load: assert property (p_load) // see [RULE8]
    else $error("pointer load lost");

  property p_ptr_inc;
    @(posedge clk_i) disable iff (rst_i)
      ptr_op_i == acps_pkg::ACPS_PTR_INC && !sel_wr |=>
        active_pointer_o == $past(active_pointer_o) + 16'h0001;
  endproperty
  a_ptr_inc: assert property (p_ptr_inc) // see [RULE8]
    else $error("pointer increment lost");

  property p_reset;
    @(posedge clk_i) state_q.reset_seen && !rst_i |->
      !pointer_select_o && !user_flag_o && !sfr_rdata_o[`ACPS_ZERO_BIT] &&
      active_pointer_o == `ACPS_POINTER_RESET && boot_space_enable_o == $past(boot_jump_fuse_i);
  endproperty
  a_reset: assert property (p_reset) // see [RULE6]
    else $error("reset state wrong");

  property p_boot;
    @(posedge clk_i) disable iff (rst_i)
      code_addr_i >= `ACPS_BOOT_BASE |-> boot_hit_o == boot_space_enable_o;
  endproperty
  a_boot: assert property (p_boot) // see [RULE1]
    else $error("boot map wrong");

  property p_boot_below;
    @(posedge clk_i) disable iff (rst_i)
      code_addr_i < `ACPS_BOOT_BASE |-> !boot_hit_o;
  endproperty
  a_boot_below: assert property (p_boot_below) // see [RULE1]
    else $error("boot map hit below window");
endmodule : acps_aux_control

// >>> sim/acps_core_model.sv
// Model of the core executing an increment of the aux control register.
`timescale 1ns/1ps
module acps_core_model (
  input wire logic clk_i,
  input wire logic inc_i,
  input wire logic [7:0] rdata_i,
  output logic wr_o,
  output logic [7:0] wdata_o
);
  initial wr_o = 1'b0;
  initial wdata_o = 8'h00;
  // The mask keeps the reserved bits clear even when the carry reaches bit 1.
  always @(posedge clk_i) begin
    wr_o <= inc_i;
    wdata_o <= (rdata_i + 8'h01) & 8'h2D;
  end
endmodule : acps_core_model

// >>> sim/tb.sv
// Self-checking bench for the aux control register block.
`timescale 1ns/1ps
module tb;
  logic clk_i = 0, rst_i = 1, fuse = 0, wr = 0, inc = 0, m_wr, hit, bh, sel, uf, be;
  logic [7:0] addr = 8'hA2, wd = 8'h00, m_wd, rd;
  logic [15:0] pw = 16'h0000, ap, ca = 16'h0000;
  acps_pkg::acps_ptr_op_t op = acps_pkg::ACPS_PTR_HOLD;
  int n_fail = 0, cmp_count = 0;
  initial forever #50 clk_i = ~clk_i;
  acps_aux_control i_acps_aux_control (.clk_i(clk_i), .rst_i(rst_i), .boot_jump_fuse_i(fuse),
    .sfr_addr_i(addr), .sfr_wr_i(wr | m_wr), .sfr_wdata_i(m_wr ? m_wd : wd), .sfr_rdata_o(rd),
    .sfr_hit_o(hit), .ptr_op_i(op), .ptr_wdata_i(pw), .active_pointer_o(ap),
    .pointer_select_o(sel), .user_flag_o(uf), .boot_space_enable_o(be), .code_addr_i(ca),
    .boot_hit_o(bh));
  acps_core_model i_acps_core_model (.clk_i(clk_i), .inc_i(inc), .rdata_i(rd), .wr_o(m_wr),
    .wdata_o(m_wd));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    wr <= 1'b1;
    wd <= d;
    @(posedge clk_i);
    wr <= 1'b0;
    addr <= 8'hA2;
    #1;
  endtask : wr_reg
  task automatic pop(input acps_pkg::acps_ptr_op_t o, input logic [15:0] d);
    @(posedge clk_i);
    op <= o;
    pw <= d;
    @(posedge clk_i);
    op <= acps_pkg::ACPS_PTR_HOLD;
    #1;
  endtask : pop
  task automatic t_reset(input logic f);
    @(posedge clk_i);
    rst_i <= 1'b1;
    fuse <= f;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    fuse <= ~f;
    #1;
    chk(rd, {10'd0, f, 5'd0});
    chk(ap, 16'h0000);
    pop(acps_pkg::ACPS_PTR_HOLD, 16'h0000);
    chk(be, f);
    $display("reset test done");
  endtask : t_reset
  task automatic t_write;
    logic [15:0] adr [3] = '{16'hF7FF, 16'hF800, 16'hFFFF};
    wr_reg(8'hA2, 8'hFF);
    chk(rd, 16'h0029);
    chk(uf, 1'b1);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_i);
      ca <= adr[i];
      #1;
      chk(bh, i > 0);
    end
    wr_reg(8'hA2, 8'h00);
    chk(bh, 1'b0);
    chk(rd, 16'h0000);
    $display("write test done");
  endtask : t_write
  task automatic t_ptr;
    pop(acps_pkg::ACPS_PTR_LOAD, 16'h1234);
    wr_reg(8'hA2, 8'h01);
    chk(sel, 1'b1);
    pop(acps_pkg::ACPS_PTR_LOAD, 16'h5678);
    pop(acps_pkg::ACPS_PTR_INC, 16'h0000);
    chk(ap, 16'h5679);
    wr_reg(8'hA2, 8'h00);
    chk(ap, 16'h1234);
    $display("pointer test done");
  endtask : t_ptr
  task automatic t_inc;
    wr_reg(8'hA2, 8'h08);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_i);
      inc <= 1'b1;
      @(posedge clk_i);
      inc <= 1'b0;
      @(posedge clk_i);
      #1;
      chk(rd, i ? 16'h0008 : 16'h0009);
    end
    chk(hit, 1'b1);
    @(posedge clk_i);
    addr <= 8'hA3;
    #1;
    chk(hit, 1'b0);
    wr_reg(8'hA3, 8'hFF);
    chk(rd, 16'h0008);
    $display("increment test done");
  endtask : t_inc
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize
  initial begin
    #1000000;
    n_fail++;
    summarize();
  end
  initial begin
    t_reset(1'b1);
    t_write();
    t_ptr();
    t_inc();
    t_reset(1'b0);
    summarize();
  end
endmodule : tb
